// ### hdl/dts_defs.svh
// constants for the training and set-point switch block: addresses, fields, resets, timing
`ifndef DTS_DEFS_SVH
`define DTS_DEFS_SVH

// ============================================================
// clock
`define DTS_CLK_MHZ            40

// ============================================================
// mode register addresses (6-bit command operand)
`define DTS_ADDR_LATENCY       6'h02
`define DTS_ADDR_CA_VREF       6'h0c
`define DTS_ADDR_SETPOINT      6'h0d
`define DTS_ADDR_MASK_LOW      6'h0f
`define DTS_ADDR_MASK_HIGH     6'h14
`define DTS_ADDR_PATTERN_FIRST 6'h20
`define DTS_ADDR_PATTERN_SECOND 6'h28

// ============================================================
// field positions
`define DTS_BIT_WL_MODE        7
`define DTS_BIT_OP_SELECT      7
`define DTS_BIT_WR_SELECT      6
`define DTS_BIT_VREF_CURRENT   3
`define DTS_BIT_VREF_RANGE     6

// ============================================================
// reset values
`define DTS_RST_PATTERN_FIRST  8'h5a
`define DTS_RST_PATTERN_SECOND 8'h3c
`define DTS_RST_MASK           8'h55
`define DTS_RST_VREF_SETTING   6'h0d
`define DTS_RST_VREF_RANGE     1'b0
`define DTS_RST_RL_CODE        3'h0

// ============================================================
// timing: times in ns, counts derived (all counts round down, floor of one)
`define DTS_AT_LEAST_ONE(x)    (((x) > 0) ? (x) : 1)
`define DTS_FC_SHORT_NS        200
`define DTS_FC_MIDDLE_NS       400
`define DTS_FC_LONG_NS         800
`define DTS_WL_FEEDBACK_NS     20
`define DTS_FC_SHORT_CYC       `DTS_AT_LEAST_ONE(`DTS_FC_SHORT_NS * `DTS_CLK_MHZ / 1000)
`define DTS_FC_MIDDLE_CYC      `DTS_AT_LEAST_ONE(`DTS_FC_MIDDLE_NS * `DTS_CLK_MHZ / 1000)
`define DTS_FC_LONG_CYC        `DTS_AT_LEAST_ONE(`DTS_FC_LONG_NS * `DTS_CLK_MHZ / 1000)
`define DTS_WL_FEEDBACK_CYC    `DTS_AT_LEAST_ONE(`DTS_WL_FEEDBACK_NS * `DTS_CLK_MHZ / 1000)
`define DTS_RL_BASE_CYC        6
`define DTS_RL_STEP_CYC        2
`define DTS_BURST_BITS         16

`endif

// ### hdl/dts_delay_timer.sv
// countdown timer: busy while counting, one-cycle done pulse at the end
`timescale 1ns/1ps
`default_nettype none
module dts_delay_timer (
	input  wire logic        core_clk,  // block clock
	input  wire logic        resetn,    // async reset, active low
	input  wire logic        start,     // load and start, restarts if busy
	input  wire logic [11:0] load,      // cycles to count, at least one
	output logic             busy,      // counting
	output logic             done       // pulse on expiry
);
	import dts_pkg::*;

	dts_timer_s st_reg;                 // all state
	dts_timer_s st_next;                // next state

	// ============================================================
	// next state
	always_comb begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		if (start) begin
			// restart wins so a new window is never shortened
			st_next.count = load;
			st_next.busy  = 1'b1;
		end else if (st_reg.busy) begin
			if (st_reg.count <= 12'h001) begin
				st_next.busy  = 1'b0;
				st_next.done  = 1'b1;
				st_next.count = 12'h000;
			end else begin
				st_next.count = st_reg.count - 12'h001;
			end
		end
	end

	// ============================================================
	// registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy = st_reg.busy;
	assign done = st_reg.done;
endmodule // dts_delay_timer
`default_nettype wire

// ### hdl/dts_pin_sync.sv
// three-stage pin synchroniser; the level moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dts_pin_sync (
	input  wire logic core_clk,   // block clock
	input  wire logic resetn,     // async reset, active low
	input  wire logic pinIn,      // asynchronous pin
	output logic      levelOut    // filtered level
);
	import dts_pkg::*;

	dts_sync_s st_reg;            // all state
	dts_sync_s st_next;           // next state

	// ============================================================
	// next state: stage one feeds only stage two
	always_comb begin
		st_next    = st_reg;
		st_next.s1 = pinIn;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		// a glitch seen by only one stage never reaches the level
		if (st_reg.s2 == st_reg.s3) begin
			st_next.level = st_reg.s3;
		end
	end

	// ============================================================
	// registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign levelOut = st_reg.level;
endmodule // dts_pin_sync
`default_nettype wire

// ### hdl/dts_pkg.sv
// types shared by the training and set-point switch block
package dts_pkg;

	// ============================================================
	// decoded command from the command/address bus
	typedef enum logic [2:0] {
		DTS_CMD_DESELECT,
		DTS_CMD_MODE_WRITE,
		DTS_CMD_READ_CAL,
		DTS_CMD_CAS_SECOND,
		DTS_CMD_ARRAY_READ,
		DTS_CMD_OTHER
	} dts_cmd_e;

	typedef struct packed {
		logic       valid;   // one-cycle strobe
		dts_cmd_e   kind;    // command type
		logic [5:0] addr;    // mode register address
		logic [7:0] data;    // operand
	} dts_cmd_s;

	// switch time class of the last set-point change
	typedef enum logic [1:0] {
		DTS_FC_NONE,
		DTS_FC_SHORT,
		DTS_FC_MIDDLE,
		DTS_FC_LONG
	} dts_fc_e;

	// one duplicated register set
	typedef struct packed {
		logic [5:0] vrefSetting;
		logic       vrefRange;
		logic [2:0] rlCode;
	} dts_setpoint_s;

	// state of the pin synchroniser
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} dts_sync_s;

	// state of a countdown timer
	typedef struct packed {
		logic [11:0] count;
		logic        busy;
		logic        done;
	} dts_timer_s;

	// state of the top block
	typedef struct packed {
		dts_setpoint_s [1:0] sets;
		logic        opSel;
		logic        wrSel;
		logic        vrefFast;
		logic        wlMode;
		logic [7:0]  patFirst;
		logic [7:0]  patSecond;
		logic [7:0]  maskLow;
		logic [7:0]  maskHigh;
		logic        calArmed;
		logic [31:0] launch;
		logic        burstOn;
		logic [3:0]  burstBit;
		logic [1:0]  wlSample;
		logic [1:0]  wlValid;
		logic [1:0]  dqsPrev;
		dts_fc_e     fcClass;
		logic [15:0] dq;
		logic [1:0]  dqOe;
		logic [1:0]  dmi;
		logic [1:0]  dmiOe;
	} dts_top_s;

endpackage

// ### hdl/dts_training_core.sv
// device-side set-point switching, write leveling feedback and read calibration pattern
`timescale 1ns/1ps
`default_nettype none
`include "dts_defs.svh"

// How it works
// R1: one vref step gives short, more middle
// R2: range change always gives long switch time
// R3: power-up on set 0, safe defaults
// R4: controller trains alternate set first
// R5: one write switches; wait the switch time
// R6: controller rewrites stored values for third point
// R7: leveling bit set enters, cleared exits
// R8: in leveling only deselect or exit write; code takes any latency-register write
// R9: strobe edge samples clock onto its byte
// R10: byte lanes and channels level independently
// R11: controller parks strobe, then waits before pulsing
// R12: every edge overwrites; feedback after delay
// R13: controller tunes delays, levels before write training
// R14: clock may stop during leveling
// R15: calibration plus CAS drives two-byte burst
// R16: pattern and mask defaults 5a, 3c, 55
// R17: mask bit inverts its own data pin
// R18: mask pins get raw pattern, no inversion
// R19: controller spaces reads and calibration reads
// R20: controller drives CAS operands low
// R21: accepted with banks open, refresh, clock enable high
// R22: same latency as a normal read
// R23: write select and operating select act independently
// R24: controller sets fast vref current when switching
module dts_training_core (
	input  wire logic              core_clk,      // controller clock, 40 MHz
	input  wire logic              resetn,        // async reset, active low
	input  wire dts_pkg::dts_cmd_s cmd,           // decoded command, same clock
	input  wire logic              clkEnable,     // clock enable level, same clock
	input  wire logic              ckLevelPin,    // clock level seen at the strobe samplers
	input  wire logic [1:0]        dqsTruePin,    // true strobes, one per byte
	output logic [15:0]            dqOut,         // data pins
	output logic [1:0]             dqOe,          // data enable, one per byte
	output logic [1:0]             dmiOut,        // mask pins
	output logic [1:0]             dmiOe,         // mask enable, one per byte
	output logic                   opSetpoint,    // set in use
	output logic                   writeSetpoint, // set written by mode writes
	output logic                   vrefFastMode,  // reference current fast
	output logic                   switchBusy,    // switch time running
	output dts_pkg::dts_fc_e       switchClass,   // class of last switch
	output logic                   levelingActive // leveling mode on
);
	import dts_pkg::*;

	// ============================================================
	// declarations
	dts_top_s    st_reg;         // all state
	dts_top_s    st_next;        // next state
	logic [2:0]  pinRaw;         // raw {clock, strobe1, strobe0}
	logic [2:0]  pinLevel;       // synchronised {clock, strobe1, strobe0}
	logic        fcStart;        // start of switch time
	logic [11:0] fcLoad;         // its length in cycles
	logic        fcBusy;         // switch time running
	logic [1:0]  wlStart;        // strobe edge per byte
	logic [1:0]  wlDone;         // feedback delay over per byte
	logic        mrWrite;        // mode write taken
	logic        calStart;       // calibration burst requested now
	logic [4:0]  rlCycles;       // read latency of the operating set
	logic [15:0] burstWord;      // {second, first} pattern
	logic        burstBitVal;    // pattern bit of this cycle
	logic        launchNow;      // delayed start reached the pins

	// ============================================================
	// pin synchronisers: strobes and clock level come from outside
	assign pinRaw = {ckLevelPin, dqsTruePin};
	for (genvar gi = 0; gi < 3; gi++) begin : g_sync
		dts_pin_sync u_sync (
			.core_clk (core_clk),
			.resetn   (resetn),
			.pinIn    (pinRaw[gi]),
			.levelOut (pinLevel[gi])
		);
	end

	// ============================================================
	// switch time timer
	dts_delay_timer u_fc_timer (
		.core_clk (core_clk),
		.resetn   (resetn),
		.start    (fcStart),
		.load     (fcLoad),
		.busy     (fcBusy),
		.done     ()
	);

	// ============================================================
	// feedback delay, one timer per byte lane so lanes level alone
	for (genvar gb = 0; gb < 2; gb++) begin : g_wl
		dts_delay_timer u_wl_timer ( // R10
			.core_clk (core_clk),
			.resetn   (resetn),
			.start    (wlStart[gb]),
			.load     (12'(`DTS_WL_FEEDBACK_CYC)),
			.busy     (),
			.done     (wlDone[gb])
		);
	end

	// ============================================================
	// switch class from old and new CA reference of the two sets
	always_comb begin
		logic [5:0] oldV;
		logic [5:0] newV;
		logic [5:0] diff;
		oldV     = '0;
		newV     = '0;
		diff     = '0;
		fcStart  = 1'b0;
		fcLoad   = 12'h000;
		oldV     = st_reg.sets[st_reg.opSel].vrefSetting;
		newV     = st_reg.sets[~st_reg.opSel].vrefSetting;
		diff     = (oldV > newV) ? (oldV - newV) : (newV - oldV);
		// a switch is one write to the set-point register that flips the operating bit
		if (mrWrite && (cmd.addr == `DTS_ADDR_SETPOINT)
			&& (cmd.data[`DTS_BIT_OP_SELECT] != st_reg.opSel)) begin
			fcStart = 1'b1; // R5
			if (st_reg.sets[0].vrefRange != st_reg.sets[1].vrefRange) begin
				fcLoad = 12'(`DTS_FC_LONG_CYC); // R2
			end else if (diff <= 6'h01) begin
				fcLoad = 12'(`DTS_FC_SHORT_CYC); // R1
			end else begin
				fcLoad = 12'(`DTS_FC_MIDDLE_CYC); // R1
			end
		end
	end

	// ============================================================
	// command qualification and burst helpers
	always_comb begin
		// in leveling mode only writes to the latency register are honoured; other mode writes are dropped
		mrWrite = cmd.valid && (cmd.kind == DTS_CMD_MODE_WRITE)
			&& (!st_reg.wlMode || (cmd.addr == `DTS_ADDR_LATENCY)); // R8
		// bank state and refresh do not matter; only the armed calibration command, a live clock enable and leveling being off do
		calStart = cmd.valid && (cmd.kind == DTS_CMD_CAS_SECOND)
			&& st_reg.calArmed && clkEnable && !st_reg.wlMode; // R15 R21
		// same latency figure as a normal read of the operating set
		rlCycles = 5'(`DTS_RL_BASE_CYC)
			+ 5'(st_reg.sets[st_reg.opSel].rlCode) * 5'(`DTS_RL_STEP_CYC); // R22
		burstWord   = {st_reg.patSecond, st_reg.patFirst}; // R15
		burstBitVal = burstWord[st_reg.burstBit];
		launchNow   = st_reg.launch[0];
		// strobe rising edge after filtering
		for (int b = 0; b < 2; b++) begin
			wlStart[b] = st_reg.wlMode && pinLevel[b] && !st_reg.dqsPrev[b]; // R9
		end
	end

	// ============================================================
	// next state
	always_comb begin
		logic [3:0] idx;  // burst bit driven in the coming cycle
		idx            = 4'h0;
		st_next        = st_reg;
		st_next.launch = {1'b0, st_reg.launch[31:1]};
		st_next.dqsPrev = pinLevel[1:0];

		// mode register writes
		if (mrWrite) begin
			if (cmd.addr == `DTS_ADDR_SETPOINT) begin
				// the two select bits are stored apart and never steer each other
				st_next.opSel    = cmd.data[`DTS_BIT_OP_SELECT]; // R23
				st_next.wrSel    = cmd.data[`DTS_BIT_WR_SELECT]; // R23
				st_next.vrefFast = cmd.data[`DTS_BIT_VREF_CURRENT];
				if (fcStart) begin
					st_next.fcClass = (fcLoad == 12'(`DTS_FC_LONG_CYC)) ? DTS_FC_LONG
						: (fcLoad == 12'(`DTS_FC_SHORT_CYC)) ? DTS_FC_SHORT : DTS_FC_MIDDLE;
				end
			end else if (cmd.addr == `DTS_ADDR_CA_VREF) begin
				// duplicated fields land in the set chosen for writing
				st_next.sets[st_reg.wrSel].vrefSetting = cmd.data[5:0]; // R23
				st_next.sets[st_reg.wrSel].vrefRange   = cmd.data[`DTS_BIT_VREF_RANGE];
			end else if (cmd.addr == `DTS_ADDR_LATENCY) begin
				st_next.sets[st_reg.wrSel].rlCode = cmd.data[2:0];
				st_next.wlMode = cmd.data[`DTS_BIT_WL_MODE]; // R7
				if (cmd.data[`DTS_BIT_WL_MODE] && !st_reg.wlMode) begin
					// data pins are undefined on entry; released until feedback
					st_next.wlValid = 2'b00; // R8
				end
			end else if (cmd.addr == `DTS_ADDR_MASK_LOW) begin
				st_next.maskLow = cmd.data;
			end else if (cmd.addr == `DTS_ADDR_MASK_HIGH) begin
				st_next.maskHigh = cmd.data;
			end else if (cmd.addr == `DTS_ADDR_PATTERN_FIRST) begin
				st_next.patFirst = cmd.data;
			end else if (cmd.addr == `DTS_ADDR_PATTERN_SECOND) begin
				st_next.patSecond = cmd.data;
			end
		end

		// calibration command arms, the next command decides
		if (cmd.valid && (cmd.kind != DTS_CMD_DESELECT)) begin
			st_next.calArmed = (cmd.kind == DTS_CMD_READ_CAL);
		end

		// schedule the burst after read latency
		if (calStart) begin
			st_next.launch[rlCycles - 5'h01] = 1'b1; // R22
		end

		// burst counter: sixteen pattern bits, one per clock
		if (launchNow) begin
			st_next.burstOn  = 1'b1;
			st_next.burstBit = 4'h0;
		end else if (st_reg.burstOn) begin
			if (st_reg.burstBit == 4'(`DTS_BURST_BITS - 1)) begin
				st_next.burstOn = 1'b0;
			end else begin
				st_next.burstBit = st_reg.burstBit + 4'h1;
			end
		end

		// leveling: each edge overwrites the held clock sample
		for (int b = 0; b < 2; b++) begin
			if (wlStart[b]) begin
				st_next.wlSample[b] = pinLevel[2]; // R12
			end
			if (wlDone[b]) begin
				st_next.wlValid[b] = 1'b1; // R12
			end
		end
		if (!st_next.wlMode) begin
			st_next.wlValid = 2'b00; // R7
		end

		// pin drivers
		st_next.dq    = '0;
		st_next.dqOe  = 2'b00;
		st_next.dmi   = 2'b00;
		st_next.dmiOe = 2'b00;
		if (st_reg.wlMode) begin
			// the clock sample of a lane goes on all eight data pins of that lane
			for (int b = 0; b < 2; b++) begin
				st_next.dq[b*8 +: 8] = {8{st_reg.wlSample[b]}}; // R9
				st_next.dqOe[b]      = st_reg.wlValid[b]; // R9
			end
		end else if (launchNow || (st_reg.burstOn
			&& (st_reg.burstBit != 4'(`DTS_BURST_BITS - 1)))) begin
			// the bit driven now is the one the counter points to next cycle
			idx = launchNow ? 4'h0 : (st_reg.burstBit + 4'h1);
			for (int p = 0; p < 8; p++) begin
				st_next.dq[p]     = burstWord[idx] ^ st_reg.maskLow[p]; // R17
				st_next.dq[p + 8] = burstWord[idx] ^ st_reg.maskHigh[p]; // R17
			end
			// mask pins get the raw pattern, no read inversion coding
			st_next.dmi   = {2{burstWord[idx]}}; // R18
			st_next.dqOe  = 2'b11;
			st_next.dmiOe = 2'b11;
		end
	end

	// ============================================================
	// registers; the whole device starts on set 0 with low-speed defaults
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg                      <= '0; // R3
			st_reg.sets[0].vrefSetting  <= `DTS_RST_VREF_SETTING; // R3
			st_reg.sets[1].vrefSetting  <= `DTS_RST_VREF_SETTING; // R3
			st_reg.sets[0].vrefRange    <= `DTS_RST_VREF_RANGE;
			st_reg.sets[1].vrefRange    <= `DTS_RST_VREF_RANGE;
			st_reg.sets[0].rlCode       <= `DTS_RST_RL_CODE;
			st_reg.sets[1].rlCode       <= `DTS_RST_RL_CODE;
			st_reg.patFirst             <= `DTS_RST_PATTERN_FIRST; // R16
			st_reg.patSecond            <= `DTS_RST_PATTERN_SECOND; // R16
			st_reg.maskLow              <= `DTS_RST_MASK; // R16
			st_reg.maskHigh             <= `DTS_RST_MASK; // R16
			st_reg.fcClass              <= DTS_FC_NONE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ============================================================
	// outputs straight from the state register
	// a stopped clock in leveling simply freezes this state; the held
	// sample and pin drive stay put until edges resume
	assign dqOut          = st_reg.dq; // R14
	assign dqOe           = st_reg.dqOe;
	assign dmiOut         = st_reg.dmi;
	assign dmiOe          = st_reg.dmiOe;
	assign opSetpoint     = st_reg.opSel;
	assign writeSetpoint  = st_reg.wrSel;
	assign vrefFastMode   = st_reg.vrefFast;
	assign switchClass    = st_reg.fcClass;
	assign levelingActive = st_reg.wlMode;

	// switch busy is the timer's own busy flop: high from the switch write for the switch time
	assign switchBusy     = fcBusy; // R5
endmodule // dts_training_core
`default_nettype wire

// ### tb/dts_ctrl_model.sv
// controller-side model driving the leveling strobes and the clock level
`timescale 1ns/1ps
`default_nettype none
module dts_ctrl_model (
	output logic       ckLevelPin, // clock level at the strobe samplers
	output logic [1:0] dqsTruePin  // true strobes, parked low
);
	// ============================================================
	// strobes parked low from leveling entry on
	initial begin
		ckLevelPin = 1'b0;
		dqsTruePin = 2'b00;
	end
	// ============================================================
	// two pulses per lane since the first edge may be lost; 60 ns steps span two clock edges,
	// so the three-flop filter keeps every level
	task automatic pulses(input int lane, input logic lvl);
		ckLevelPin = lvl;
		repeat (2) begin
			#60 dqsTruePin[lane] = 1'b1;
			#60 dqsTruePin[lane] = 1'b0;
		end
		#300;
	endtask
endmodule // dts_ctrl_model
`default_nettype wire

// ### tb/dts_training_monitor.sv
// port-level assertion checker for the training and set-point switch core
`timescale 1ns/1ps
`default_nettype none
module dts_training_monitor import dts_pkg::*; (
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire dts_cmd_s   cmd,
	input wire logic       clkEnable,
	input wire logic       ckLevelPin,
	input wire logic [1:0] dqsTruePin,
	input wire logic [15:0] dqOut,
	input wire logic [1:0] dqOe,
	input wire logic [1:0] dmiOut,
	input wire logic [1:0] dmiOe,
	input wire logic       opSetpoint,
	input wire logic       writeSetpoint,
	input wire logic       vrefFastMode,
	input wire logic       switchBusy,
	input wire dts_fc_e    switchClass,
	input wire logic       levelingActive
);
	// ============================================================
	// one clock domain, so clocking and disable are given once
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire logic wr = cmd.valid && cmd.kind == DTS_CMD_MODE_WRITE; // a mode write on the bus, taken or refused
	logic [7:0] burstRun; // cycles the mask pins have been driven in a row
	// ============================================================
	// helper count: a long burst is counted here rather than unrolled as a repetition
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			burstRun <= 8'h00;
		end else begin
			burstRun <= (dmiOe == 2'b11) ? burstRun + 8'h01 : 8'h00;
		end
	end
	// ============================================================
	// calibration steps: pattern command, then the second cas with clock enable high
	sequence s_cal_go;
		cmd.valid && cmd.kind == DTS_CMD_READ_CAL ##1
		cmd.valid && cmd.kind == DTS_CMD_CAS_SECOND && clkEnable && !levelingActive;
	endsequence
	sequence s_burst;
		(dmiOe == 2'b11) ##1 (dmiOe == 2'b00);
	endsequence
	// ============================================================
	// assertions
	a_reset_state: assert property ($rose(resetn) |-> !opSetpoint && switchClass == DTS_FC_NONE && !levelingActive)
		else $error("state after reset wrong");
	a_op_write: assert property (wr && cmd.addr == 6'h0d && !levelingActive |=> opSetpoint == $past(cmd.data[7])
		&& writeSetpoint == $past(cmd.data[6]) && vrefFastMode == $past(cmd.data[3])) else $error("select write lost");
	a_wl_entry: assert property (wr && cmd.addr == 6'h02 |=> levelingActive == $past(cmd.data[7]))
		else $error("leveling bit not followed");
	a_wl_refuse: assert property (wr && cmd.addr == 6'h0d && levelingActive |=> $stable(opSetpoint))
		else $error("write taken in leveling");
	a_switch_busy: assert property ($changed(opSetpoint) |-> switchBusy && switchClass != DTS_FC_NONE)
		else $error("switch without busy");
	a_long_hold: assert property ($fell(switchBusy) && switchClass == DTS_FC_LONG |-> $past(switchBusy, 24))
		else $error("long switch too short");
	a_wl_copies: assert property (levelingActive && dqOe[1] |-> dqOut[15:8] == 8'h00 || dqOut[15:8] == 8'hff)
		else $error("feedback byte mixed");
	a_wl_exit: assert property ($fell(levelingActive) |-> ##[0:1] dqOe == 2'b00)
		else $error("pins driven after exit");
	a_cal_launch: assert property (s_cal_go |-> ##[5:21] dmiOe == 2'b11)
		else $error("no calibration burst");
	a_burst_len: assert property (s_burst |-> burstRun == 8'd16)
		else $error("burst length wrong");
	a_dmi_raw: assert property (dmiOe[0] |-> dmiOut[0] == dmiOut[1] && dqOe == 2'b11)
		else $error("mask pins differ");
endmodule // dts_training_monitor
bind dts_training_core dts_training_monitor u_mon (.core_clk(core_clk), .resetn(resetn), .cmd(cmd),
	.clkEnable(clkEnable), .ckLevelPin(ckLevelPin), .dqsTruePin(dqsTruePin), .dqOut(dqOut), .dqOe(dqOe),
	.dmiOut(dmiOut), .dmiOe(dmiOe), .opSetpoint(opSetpoint), .writeSetpoint(writeSetpoint),
	.vrefFastMode(vrefFastMode), .switchBusy(switchBusy), .switchClass(switchClass),
	.levelingActive(levelingActive));
`default_nettype wire

// ### tb/test_dts_training_core.sv
// testbench: mode writes, set-point switches, leveling feedback and calibration bursts
`timescale 1ns/1ps
`default_nettype none
`include "dts_defs.svh"
module test_dts_training_core;
	import dts_pkg::*;
	// ============================================================
	// signals
	logic        core_clk = 1'b0;  // 40 MHz
	logic        resetn;           // active low
	dts_cmd_s    cmd;              // command strobe and operands
	logic        clkEnable;        // calibration needs it high
	logic        ckLevelPin;       // from the controller model
	logic [1:0]  dqsTruePin;       // from the controller model
	logic [15:0] dqOut;
	logic [1:0]  dqOe, dmiOut, dmiOe;
	logic        opSetpoint, writeSetpoint, vrefFastMode, switchBusy, levelingActive;
	dts_fc_e     switchClass;
	int          mismatches = 0;
	int          total_checks = 0;
	logic [7:0]  vr [3] = '{8'h0e, 8'h0f, 8'h4d}; // one step, two steps, range change
	dts_fc_e     cl [3] = '{DTS_FC_SHORT, DTS_FC_MIDDLE, DTS_FC_LONG};
	int          ld [3] = '{`DTS_FC_SHORT_CYC, `DTS_FC_MIDDLE_CYC, `DTS_FC_LONG_CYC};
	always #12.5 core_clk = ~core_clk;
	// ============================================================
	// instances
	dts_training_core dut (.core_clk(core_clk), .resetn(resetn), .cmd(cmd), .clkEnable(clkEnable),
		.ckLevelPin(ckLevelPin), .dqsTruePin(dqsTruePin), .dqOut(dqOut), .dqOe(dqOe), .dmiOut(dmiOut),
		.dmiOe(dmiOe), .opSetpoint(opSetpoint), .writeSetpoint(writeSetpoint), .vrefFastMode(vrefFastMode),
		.switchBusy(switchBusy), .switchClass(switchClass), .levelingActive(levelingActive));
	dts_ctrl_model ctrl (.ckLevelPin(ckLevelPin), .dqsTruePin(dqsTruePin));
	// ============================================================
	// shared tasks; inputs move 1 ns after the rising edge
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// valid stays up through one edge; callers lower it themselves
	task automatic issue(input dts_cmd_e k, input logic [5:0] a, input logic [7:0] d);
		cmd = '{1'b1, k, a, d};
		cyc(1);
	endtask
	task automatic write(input logic [5:0] a, input logic [7:0] d);
		issue(DTS_CMD_MODE_WRITE, a, d);
		cmd.valid = 1'b0;
		cyc(1);
	endtask
	// mode 0 normal, 1 clock enable low, 2 second cas alone; refused modes must stay silent
	task automatic cal(input logic [7:0] f, s, ml, mh, input int rl, input int mode);
		logic [15:0] p;
		logic        b;
		int          n;
		p = {s, f};
		n = 0;
		clkEnable = (mode != 1);
		if (mode != 2) begin
			issue(DTS_CMD_READ_CAL, 6'h00, 8'h00);
		end
		issue(DTS_CMD_CAS_SECOND, 6'h00, 8'h00);
		cmd.valid = 1'b0;
		clkEnable = 1'b1;
		while (dmiOe !== 2'b11 && n < 30) begin
			cyc(1);
			n++;
		end
		if (mode != 0) begin
			chk(18'(n), 18'd30);
			return;
		end
		chk(n >= rl - 1 && n <= rl + 1, 1);
		if (n == 30) wrap_up();
		for (int i = 0; i < 16; i++) begin
			b = p[i];
			chk({dmiOut, dqOut}, {{2{b}}, {8{b}} ^ mh, {8{b}} ^ ml});
			cyc(1);
		end
		chk({dqOe, dmiOe}, 0);
	endtask
	// switch write, then time the busy level against the class figure
	task automatic sw(input logic [7:0] d, input dts_fc_e c, input int load);
		int n;
		n = 0;
		write(6'h0d, d);
		chk({opSetpoint, vrefFastMode, switchBusy, switchClass}, {d[7], d[3], 1'b1, c});
		while (switchBusy === 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		chk(n >= load - 2 && n <= load + 2, 1);
		if (n == 100) wrap_up();
	endtask
	// ============================================================
	// main sequence
	initial begin
		cmd = '0;
		clkEnable = 1'b1;
		resetn = 1'b0;
		cyc(3);
		resetn = 1'b1;
		chk({opSetpoint, writeSetpoint, vrefFastMode, switchBusy, switchClass, levelingActive, dqOe, dmiOe}, 0);
		cal(8'h5a, 8'h3c, 8'h55, 8'h55, `DTS_RL_BASE_CYC, 0);
		cal(8'h5a, 8'h3c, 8'h55, 8'h55, `DTS_RL_BASE_CYC, 1);
		cal(8'h5a, 8'h3c, 8'h55, 8'h55, `DTS_RL_BASE_CYC, 2);
		$display("test defaults done");
		write(6'h0d, 8'h40);
		chk({writeSetpoint, opSetpoint}, 2'b10);
		for (int i = 0; i < 3; i++) begin
			write(6'h0c, vr[i]);
			sw(8'hc8, cl[i], ld[i]);
			sw(8'h48, cl[i], ld[i]);
		end
		$display("test setpoint switch done");
		write(6'h02, 8'h80);
		chk({levelingActive, dqOe}, 3'b100);
		ctrl.pulses(0, 1'b1);
		cyc(1);
		chk({dqOe, dqOut[7:0]}, {2'b01, 8'hff});
		ctrl.pulses(1, 1'b0);
		cyc(1);
		chk({dqOe, dqOut}, {2'b11, 16'h00ff});
		ctrl.pulses(0, 1'b0);
		cyc(1);
		chk(dqOut, 16'h0000);
		write(6'h20, 8'h11);
		write(6'h0d, 8'h80);
		chk(opSetpoint, 0);
		write(6'h02, 8'h00);
		chk({levelingActive, dqOe}, 0);
		$display("test leveling done");
		cal(8'h5a, 8'h3c, 8'h55, 8'h55, `DTS_RL_BASE_CYC, 0);
		write(6'h20, 8'h1c);
		write(6'h28, 8'h59);
		write(6'h0f, 8'h0f);
		write(6'h14, 8'h81);
		cal(8'h1c, 8'h59, 8'h0f, 8'h81, `DTS_RL_BASE_CYC, 0);
		write(6'h02, 8'h01);
		cal(8'h1c, 8'h59, 8'h0f, 8'h81, `DTS_RL_BASE_CYC, 0);
		sw(8'hc8, DTS_FC_LONG, `DTS_FC_LONG_CYC);
		cal(8'h1c, 8'h59, 8'h0f, 8'h81, `DTS_RL_BASE_CYC + `DTS_RL_STEP_CYC, 0);
		$display("test calibration done");
		wrap_up();
	end
endmodule // test_dts_training_core
`default_nettype wire
